// *** hdl/bit_sync.sv ***
/*
  Two flip-flop level synchroniser with synchronous active-low reset.
  Assumes d_i is a level or toggle from another clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module bit_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // level
  input  wire logic d_i,
  output var  logic q_o
);

  logic meta_r;

  // first stage is read by the second stage only
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      meta_r <= RST_VAL;
      q_o    <= RST_VAL;
    end
    else
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule

`default_nettype wire

// *** hdl/link_shifter.sv ***
/*
  Link-side shifter clocked by the programmer's serial clock.
  Assumes the external reset pin is high outside programming, which
  clears the bit position so each session starts in byte order.
*/
`timescale 1ns/10ps
`default_nettype none

module link_shifter
  import spi_prog_pkg::*;
(
  // link
  input  wire logic                 sck_i,
  input  wire logic                 ext_reset_b_i,
  input  wire logic                 mosi_i,
  output wire logic                 miso_o,
  // to and from the core
  input  wire spi_prog_pkg::rsp_t   rsp_i,
  output var  spi_prog_pkg::instr_t hdr_o,
  output var  logic                 hdr_tgl_o,
  output var  spi_prog_pkg::instr_t cmd_o,
  output var  logic                 cmd_tgl_o
);

  import spi_prog_pkg::*;

  logic [4:0]  bit_cnt_r;
  logic [31:0] word_r;
  logic [7:0]  last_byte_r;
  logic [7:0]  out_r;
  logic [31:0] word_nxt;

  assign word_nxt = {word_r[30:0], mosi_i};
  assign miso_o   = out_r[7];

  always_ff @(posedge sck_i or posedge ext_reset_b_i)
  begin
    if (ext_reset_b_i)
    begin
      bit_cnt_r   <= 5'h00;
      word_r      <= 32'h0000_0000;
      last_byte_r <= 8'h00;
      hdr_o       <= '0;
      hdr_tgl_o   <= 1'b0;
      cmd_o       <= '0;
      cmd_tgl_o   <= 1'b0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
      word_r    <= word_nxt;
      if (bit_cnt_r[2:0] == BYTE_LAST)
        last_byte_r <= word_nxt[7:0];
      // three bytes suffice to look up read data
      if (bit_cnt_r == HDR_LAST_BIT)
      begin
        hdr_o     <= {word_nxt[23:0], 8'h00};
        hdr_tgl_o <= ~hdr_tgl_o;
      end
      if (bit_cnt_r == CMD_LAST_BIT)
      begin
        cmd_o     <= word_nxt;
        cmd_tgl_o <= ~cmd_tgl_o;
      end
    end
  end

  always_ff @(negedge sck_i or posedge ext_reset_b_i)
  begin
    if (ext_reset_b_i)
      out_r <= 8'h00;
    else if (bit_cnt_r[2:0] == 3'h0)
    begin
      if (bit_cnt_r == RSP_LOAD_BIT && rsp_i.hit)
        out_r <= rsp_i.data;
      else
        out_r <= last_byte_r;
    end
    else
      out_r <= {out_r[6:0], 1'b0};
  end

endmodule

`default_nettype wire

// *** hdl/serial_program_command_decoder.sv ***
/*
  Serial programming command decoder: program memory, nonvolatile data
  array, page buffer, lock bits and fuses, driven by four-byte instructions.
  Assumes the programmer pauses or slows the serial clock after the third
  byte long enough for read data to be looked up in the core domain.
*/
`timescale 1ns/10ps
`default_nettype none

module serial_program_command_decoder
  import spi_prog_pkg::*;
#(
  parameter int unsigned FLASH_WAIT  = spi_prog_pkg::FLASH_CYC,
  parameter int unsigned EEPROM_WAIT = spi_prog_pkg::EEPROM_CYC,
  parameter int unsigned FUSE_WAIT   = spi_prog_pkg::FUSE_CYC,
  parameter int unsigned ERASE_WAIT  = spi_prog_pkg::ERASE_CYC
) (
  // core clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // programming link
  input  wire logic       ext_reset_b_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  output wire logic       miso_o,
  output wire logic       miso_oe_o,
  // status
  output wire logic       prog_mode_o,
  output var  logic       prog_enabled_o,
  output wire logic       busy_o,
  // nonvolatile settings
  output var  logic [5:0] lock_bits_o,
  output var  logic [7:0] fuse_lo_o,
  output var  logic [7:0] fuse_hi_o,
  output var  logic [1:0] fuse_ext_o
);

  import spi_prog_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PAGE, ST_WAIT} state_t;
  typedef enum logic [2:0] {K_NONE, K_ERASE, K_PAGE, K_EE, K_FUSE} kind_t;

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic [15:0] flash_mem [0:(1 << FLASH_AW) - 1];
  logic [7:0]  ee_mem    [0:(1 << EE_AW) - 1];
  logic [15:0] pbuf_mem  [0:(1 << PAGE_AW) - 1];

  // -----------------------------------------------------------------
  // link and crossings
  // -----------------------------------------------------------------
  instr_t hdr_w;
  instr_t cmd_w;
  rsp_t   rsp_r;
  logic   hdr_tgl_w;
  logic   cmd_tgl_w;
  logic   hdr_tgl_s;
  logic   cmd_tgl_s;
  logic   hdr_seen_r;
  logic   cmd_seen_r;
  logic   ext_reset_s;
  logic   hdr_ev;
  logic   cmd_ev;

  link_shifter u_link (
    .sck_i         (sck_i),
    .ext_reset_b_i (ext_reset_b_i),
    .mosi_i        (mosi_i),
    .miso_o        (miso_o),
    .rsp_i         (rsp_r),
    .hdr_o         (hdr_w),
    .hdr_tgl_o     (hdr_tgl_w),
    .cmd_o         (cmd_w),
    .cmd_tgl_o     (cmd_tgl_w)
  );

  bit_sync #(.RST_VAL(1'b1)) u_sync_rst (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (ext_reset_b_i),
    .q_o     (ext_reset_s)
  );

  bit_sync #(.RST_VAL(1'b0)) u_sync_hdr (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (hdr_tgl_w),
    .q_o     (hdr_tgl_s)
  );

  bit_sync #(.RST_VAL(1'b0)) u_sync_cmd (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (cmd_tgl_w),
    .q_o     (cmd_tgl_s)
  );

  // words are held stable by the link until the next toggle
  assign hdr_ev      = hdr_tgl_s ^ hdr_seen_r;
  assign cmd_ev      = cmd_tgl_s ^ cmd_seen_r;
  assign prog_mode_o = ~ext_reset_s;
  assign miso_oe_o   = prog_mode_o;

  // -----------------------------------------------------------------
  // header decode for reads
  // -----------------------------------------------------------------
  logic [FLASH_AW-1:0] rd_faddr;
  logic [EE_AW-1:0]    rd_eaddr;
  logic [15:0]         rd_fword;
  logic                is_rd_flash;
  logic                is_rd_ee;
  logic                is_rd_lock;
  logic                is_rd_flo;
  logic                is_rd_fext;
  logic                is_rd_fhi;
  logic                flash_hold;
  logic                ee_hold;
  logic [7:0]          rd_fbyte;
  logic [7:0]          rd_ebyte;

  assign is_rd_flash = hdr_w.b1[7:4] == OP_RD_FLASH && hdr_w.b1[2:0] == 3'h0;
  assign rd_faddr    = {hdr_w.b2[6:0], hdr_w.b3};
  assign is_rd_ee    = hdr_w.b1 == OP_RD_EE;
  assign rd_eaddr    = {hdr_w.b2[2:0], hdr_w.b3};
  assign is_rd_lock  = hdr_w.b1 == OP_RD_LOCK && hdr_w.b2 == B2_ZERO;
  assign is_rd_flo   = hdr_w.b1 == OP_RD_FUSE && hdr_w.b2 == B2_ZERO;
  assign is_rd_fext  = hdr_w.b1 == OP_RD_FUSE && hdr_w.b2 == B2_ALT;
  assign is_rd_fhi   = hdr_w.b1 == OP_RD_LOCK && hdr_w.b2 == B2_ALT;

  state_t              state_r;
  kind_t               kind_r;
  logic [PAGE_NW-1:0]  page_r;
  logic [EE_AW-1:0]    ee_addr_r;

  assign flash_hold = (kind_r == K_ERASE) ||
                      (kind_r == K_PAGE && rd_faddr[FLASH_AW-1:PAGE_AW] == page_r);
  assign ee_hold    = (kind_r == K_ERASE) || (kind_r == K_EE && rd_eaddr == ee_addr_r);
  assign rd_fword   = flash_mem[rd_faddr];
  assign rd_fbyte   = flash_hold ? ERASED_BYTE : (hdr_w.b1[3] ? rd_fword[15:8] : rd_fword[7:0]);
  assign rd_ebyte   = ee_hold ? ERASED_BYTE : ee_mem[rd_eaddr];

  rsp_t rsp_nxt;

  always_comb
  begin
    rsp_nxt = '{hit: 1'b0, data: NO_DATA};
    if (prog_enabled_o)
    begin
      if (is_rd_flash)
        rsp_nxt = '{hit: 1'b1, data: rd_fbyte};
      else if (is_rd_ee)
        rsp_nxt = '{hit: 1'b1, data: rd_ebyte};
      else if (is_rd_lock)
        rsp_nxt = '{hit: 1'b1, data: {2'h3, lock_bits_o}};
      else if (is_rd_flo)
        rsp_nxt = '{hit: 1'b1, data: fuse_lo_o};
      else if (is_rd_fext)
        rsp_nxt = '{hit: 1'b1, data: {6'h3f, fuse_ext_o}};
      else if (is_rd_fhi)
        rsp_nxt = '{hit: 1'b1, data: fuse_hi_o};
    end
  end

  // -----------------------------------------------------------------
  // full instruction decode
  // -----------------------------------------------------------------
  logic is_en;
  logic is_erase;
  logic is_ld_page;
  logic is_wr_page;
  logic is_wr_ee;
  logic is_wr_lock;
  logic is_wr_flo;
  logic is_wr_fhi;
  logic is_wr_fext;
  logic exec_ok;

  assign is_en      = cmd_w.b1 == OP_ENABLE && cmd_w.b2 == EN_SIG_B2;
  assign is_erase   = cmd_w.b1 == OP_ENABLE && cmd_w.b2[7:5] == B2_ERASE;
  assign is_ld_page = cmd_w.b1[7:4] == OP_LD_PAGE && cmd_w.b1[2:0] == 3'h0;
  assign is_wr_page = cmd_w.b1 == OP_WR_PAGE;
  assign is_wr_ee   = cmd_w.b1 == OP_WR_EE;
  assign is_wr_lock = cmd_w.b1 == OP_ENABLE && cmd_w.b2[7:5] == B2_LOCK;
  assign is_wr_flo  = cmd_w.b1 == OP_ENABLE && cmd_w.b2 == B2_FUSE_LO;
  assign is_wr_fhi  = cmd_w.b1 == OP_ENABLE && cmd_w.b2 == B2_FUSE_HI;
  assign is_wr_fext = cmd_w.b1 == OP_ENABLE && cmd_w.b2 == B2_FUSE_EXT;
  // writes while busy would corrupt the cell in flight, so drop them
  assign exec_ok    = cmd_ev && prog_enabled_o && state_r == ST_IDLE;
  assign busy_o     = state_r != ST_IDLE;

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  logic [FLASH_AW-1:0] walk_r;
  logic [TIMER_W-1:0]  timer_r;
  logic                walk_end;
  logic                start_wait;
  logic [TIMER_W-1:0]  wait_load;

  assign walk_end   = (state_r == ST_ERASE) ? (&walk_r) : (&walk_r[PAGE_AW-1:0]);
  assign start_wait = exec_ok && (is_wr_ee || is_wr_lock || is_wr_flo || is_wr_fhi || is_wr_fext);
  assign wait_load  = is_wr_ee ? TIMER_W'(EEPROM_WAIT - 1) : TIMER_W'(FUSE_WAIT - 1);

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state_r        <= ST_IDLE;
      kind_r         <= K_NONE;
      walk_r         <= '0;
      timer_r        <= '0;
      page_r         <= '0;
      ee_addr_r      <= '0;
      hdr_seen_r     <= 1'b0;
      cmd_seen_r     <= 1'b0;
      rsp_r          <= '{hit: 1'b0, data: NO_DATA};
      prog_enabled_o <= 1'b0;
    end
    else
    begin
      hdr_seen_r <= hdr_tgl_s;
      cmd_seen_r <= cmd_tgl_s;
      if (hdr_ev)
        rsp_r <= rsp_nxt;
      if (!prog_mode_o)
        prog_enabled_o <= 1'b0;
      else if (cmd_ev && is_en)
        prog_enabled_o <= 1'b1;
      if (timer_r != '0)
        timer_r <= timer_r - TIMER_W'(1);
      case (state_r)
        ST_IDLE:
        begin
          walk_r <= '0;
          if (exec_ok && is_erase)
          begin
            state_r <= ST_ERASE;
            kind_r  <= K_ERASE;
            timer_r <= TIMER_W'(ERASE_WAIT - 1);
          end
          else if (exec_ok && is_wr_page)
          begin
            state_r <= ST_PAGE;
            kind_r  <= K_PAGE;
            page_r  <= {cmd_w.b2[6:0], cmd_w.b3[7]};
            timer_r <= TIMER_W'(FLASH_WAIT - 1);
          end
          else if (start_wait)
          begin
            state_r   <= ST_WAIT;
            kind_r    <= is_wr_ee ? K_EE : K_FUSE;
            ee_addr_r <= {cmd_w.b2[2:0], cmd_w.b3};
            timer_r   <= wait_load;
          end
        end
        ST_ERASE, ST_PAGE:
        begin
          walk_r <= walk_r + FLASH_AW'(1);
          if (walk_end)
            state_r <= ST_WAIT;
        end
        ST_WAIT:
        begin
          // flash and data values visible after the wait; lock bits and fuses change at once
          if (timer_r == '0)
          begin
            state_r <= ST_IDLE;
            kind_r  <= K_NONE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
          kind_r  <= K_NONE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // memory writes
  // -----------------------------------------------------------------
  logic                flash_we;
  logic [FLASH_AW-1:0] flash_wa;
  logic [15:0]         flash_wd;
  logic                ee_we;
  logic [EE_AW-1:0]    ee_wa;
  logic [7:0]          ee_wd;
  logic                pbuf_we;
  logic [PAGE_AW-1:0]  pbuf_wa;

  // erase walks every location to ff
  assign flash_we = state_r == ST_ERASE || state_r == ST_PAGE;
  assign flash_wa = (state_r == ST_ERASE) ? walk_r : {page_r, walk_r[PAGE_AW-1:0]};
  assign flash_wd = (state_r == ST_ERASE) ? ERASED_WORD : pbuf_mem[walk_r[PAGE_AW-1:0]];
  assign ee_we    = (state_r == ST_ERASE) || (exec_ok && is_wr_ee);
  assign ee_wa    = (state_r == ST_ERASE) ? walk_r[EE_AW-1:0] : {cmd_w.b2[2:0], cmd_w.b3};
  assign ee_wd    = (state_r == ST_ERASE) ? ERASED_BYTE : cmd_w.b4;
  assign pbuf_we  = exec_ok && is_ld_page;
  assign pbuf_wa  = cmd_w.b3[PAGE_AW-1:0];

  always_ff @(posedge clk_i)
  begin
    if (flash_we)
      flash_mem[flash_wa] <= flash_wd;
    if (ee_we)
      ee_mem[ee_wa] <= ee_wd;
  end

  always_ff @(posedge clk_i)
  begin
    if (pbuf_we && cmd_w.b1[3])
      pbuf_mem[pbuf_wa][15:8] <= cmd_w.b4;
    if (pbuf_we && !cmd_w.b1[3])
      pbuf_mem[pbuf_wa][7:0] <= cmd_w.b4;
  end

  // -----------------------------------------------------------------
  // lock bits and fuses
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      lock_bits_o <= LOCK_RST;
      fuse_lo_o   <= FUSE_LO_RST;
      fuse_hi_o   <= FUSE_HI_RST;
      fuse_ext_o  <= FUSE_EXT_RST;
    end
    else
    begin
      // lock bits: zeros program, ones leave as is; low and high fuses take the written byte as is, extended fuse its low two bits
      if (exec_ok && is_wr_lock)
        lock_bits_o <= lock_bits_o & cmd_w.b4[5:0];
      if (exec_ok && is_wr_flo)
        fuse_lo_o <= cmd_w.b4;
      if (exec_ok && is_wr_fhi)
        fuse_hi_o <= cmd_w.b4;
      if (exec_ok && is_wr_fext)
        fuse_ext_o <= cmd_w.b4[1:0];
    end
  end

endmodule

`default_nettype wire

// *** hdl/spi_prog_pkg.sv ***
/*
  Constants, field layouts, timing counts and carrier types for the
  serial programming command decoder.
  Assumes a 40 MHz core clock and a programmer that acts as link master.
*/

package spi_prog_pkg;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned T_WD_FLASH_US  = 4500;
  localparam int unsigned T_WD_EEPROM_US = 9000;
  localparam int unsigned T_WD_FUSE_US   = 4500;
  localparam int unsigned T_WD_ERASE_US  = 9000;
  // least waits, rounded up to whole cycles
  localparam int unsigned FLASH_CYC  = (T_WD_FLASH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EEPROM_CYC = (T_WD_EEPROM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FUSE_CYC   = (T_WD_FUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ERASE_CYC  = (T_WD_ERASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W    = 19;

  // -----------------------------------------------------------------
  // widths and link positions
  // -----------------------------------------------------------------
  localparam int unsigned FLASH_AW = 15;
  localparam int unsigned EE_AW    = 11;
  localparam int unsigned PAGE_AW  = 7;
  localparam int unsigned PAGE_NW  = 8;
  localparam logic [4:0]  HDR_LAST_BIT = 5'h17;
  localparam logic [4:0]  CMD_LAST_BIT = 5'h1f;
  localparam logic [4:0]  RSP_LOAD_BIT = 5'h18;
  localparam logic [2:0]  BYTE_LAST    = 3'h7;

  // -----------------------------------------------------------------
  // instruction codes
  // -----------------------------------------------------------------
  localparam logic [7:0] OP_ENABLE   = 8'hac;
  localparam logic [7:0] EN_SIG_B2   = 8'h53;
  localparam logic [3:0] OP_RD_FLASH = 4'h2;
  localparam logic [3:0] OP_LD_PAGE  = 4'h4;
  localparam logic [7:0] OP_WR_PAGE  = 8'h4c;
  localparam logic [7:0] OP_RD_EE    = 8'ha0;
  localparam logic [7:0] OP_WR_EE    = 8'hc0;
  localparam logic [7:0] OP_RD_LOCK  = 8'h58;
  localparam logic [7:0] OP_RD_FUSE  = 8'h50;
  localparam logic [7:0] B2_ZERO     = 8'h00;
  localparam logic [7:0] B2_ALT      = 8'h08;
  localparam logic [2:0] B2_ERASE    = 3'h4;
  localparam logic [2:0] B2_LOCK     = 3'h7;
  localparam logic [7:0] B2_FUSE_LO  = 8'ha0;
  localparam logic [7:0] B2_FUSE_HI  = 8'ha8;
  localparam logic [7:0] B2_FUSE_EXT = 8'ha4;

  // -----------------------------------------------------------------
  // reset and erased values
  // -----------------------------------------------------------------
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam logic [5:0]  LOCK_RST     = 6'h3f;
  localparam logic [7:0]  FUSE_LO_RST  = 8'hff;
  localparam logic [7:0]  FUSE_HI_RST  = 8'hff;
  localparam logic [1:0]  FUSE_EXT_RST = 2'h3;
  localparam logic [7:0]  NO_DATA      = 8'h00;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } instr_t;

  typedef struct packed {
    logic       hit;
    logic [7:0] data;
  } rsp_t;

endpackage

// *** verification/isp_programmer.sv ***
/*
  Programmer model: link master with a 12 ns serial clock.
  Assumes the bench calls start to open each session, then send per instruction.
*/
`timescale 1ns/10ps
`default_nettype none

module isp_programmer (
  // link
  output var  logic sck_o,
  output var  logic mosi_o,
  output var  logic ext_reset_b_o,
  input  wire logic miso_i
);
  initial
  begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    ext_reset_b_o = 1'b1;
  end

  task automatic start();
    ext_reset_b_o = 1'b0;
    #200;
  endtask

  // session end, pin high clears the link side
  task automatic stop();
    ext_reset_b_o = 1'b1;
    #200;
  endtask

  task automatic send(input logic [31:0] w, output logic [31:0] r);
    for (int i = 31; i >= 0; i--)
    begin
      mosi_o = w[i];
      #6 sck_o = 1'b1;
      r[i] = miso_i;
      // core needs time to fetch read data
      if (i == 8)
        #250;
      else
        #6;
      sck_o = 1'b0;
    end
    // no stale bit between frames
    mosi_o = ~w[0];
    #200;
  endtask
endmodule

`default_nettype wire

// *** verification/prog_cmd_asserts.sv ***
/*
  Port checker for the serial programming decoder.
  Assumes binding to the decoder top; core clock domain only.
*/
`timescale 1ns/10ps
`default_nettype none

module prog_cmd_checker #(
  parameter int unsigned ERASE_WAIT = 33000
) (
  // core
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  input wire logic       ext_reset_b_i,
  // status
  input wire logic       miso_oe_o,
  input wire logic       prog_mode_o,
  input wire logic       prog_enabled_o,
  input wire logic       busy_o,
  input wire logic [5:0] lock_bits_o,
  input wire logic [7:0] fuse_lo_o,
  input wire logic [7:0] fuse_hi_o,
  input wire logic [1:0] fuse_ext_o
);
  logic [19:0] busy_cnt_r;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // length of the current busy run
  always_ff @(posedge clk_i)
    busy_cnt_r <= busy_o ? busy_cnt_r + 20'h00001 : 20'h00000;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_EN_CLEAR: assert property (!prog_mode_o [*2] |-> !prog_enabled_o)
    else $error("enable kept outside mode");
  AST_EN_IN_MODE: assert property ($rose(prog_enabled_o) |-> prog_mode_o)
    else $error("enable set outside mode");
  AST_BUSY_NEEDS_EN: assert property ($rose(busy_o) |-> prog_enabled_o)
    else $error("operation before enable");
  AST_MODE_ON: assert property (!ext_reset_b_i [*5] |-> prog_mode_o)
    else $error("mode not entered");
  AST_MODE_OFF: assert property (ext_reset_b_i [*5] |-> !prog_mode_o)
    else $error("mode not left");
  AST_LOCK_NO_UNPROG: assert property ((lock_bits_o & ~$past(lock_bits_o)) == 6'h00)
    else $error("lock bit unprogrammed");
  AST_LOCK_NEEDS_EN: assert property ($changed(lock_bits_o) |->
    $past(prog_enabled_o || busy_o))
    else $error("lock change while idle");
  AST_FUSE_NEEDS_EN: assert property ($changed({fuse_lo_o, fuse_hi_o, fuse_ext_o}) |->
    $past(prog_enabled_o || busy_o))
    else $error("fuse change while idle");
  AST_OE_MODE: assert property (!ext_reset_b_i [*5] |-> miso_oe_o)
    else $error("serial out enable wrong");
  AST_BUSY_MAX: assert property (busy_cnt_r <= ERASE_WAIT + 300)
    else $error("busy too long");

  cover property ($fell(busy_o));
  cover property ($rose(prog_enabled_o));
  cover property ($changed(fuse_ext_o));
endmodule

bind serial_program_command_decoder prog_cmd_checker #(.ERASE_WAIT(ERASE_WAIT)) chk_u (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .ext_reset_b_i(ext_reset_b_i), .miso_oe_o(miso_oe_o),
  .prog_mode_o(prog_mode_o), .prog_enabled_o(prog_enabled_o), .busy_o(busy_o),
  .lock_bits_o(lock_bits_o), .fuse_lo_o(fuse_lo_o), .fuse_hi_o(fuse_hi_o),
  .fuse_ext_o(fuse_ext_o)
);

`default_nettype wire

// *** verification/testbench.sv ***
/*
  Self-checking bench for the serial programming decoder.
  Assumes the programmer model drives the link, checker is bound.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import spi_prog_pkg::*;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic            clk = 1'b0;
  logic            rst_b = 1'b0;
  wire logic       sck, mosi, ext_b, miso, miso_oe, mode, en, busy;
  wire logic [5:0] lock;
  wire logic [7:0] f_lo, f_hi;
  wire logic [1:0] f_ext;
  logic [31:0]     r;
  int              mismatches = 0;
  int              num_checks = 0;
  int              cycles = 0;

  always #12.5 clk = ~clk;

  serial_program_command_decoder #(
    .FLASH_WAIT(200), .EEPROM_WAIT(400), .FUSE_WAIT(200), .ERASE_WAIT(33000)
  ) dut_u (
    .clk_i(clk), .rst_b_i(rst_b), .ext_reset_b_i(ext_b), .sck_i(sck), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .prog_mode_o(mode), .prog_enabled_o(en),
    .busy_o(busy), .lock_bits_o(lock), .fuse_lo_o(f_lo), .fuse_hi_o(f_hi), .fuse_ext_o(f_ext)
  );

  isp_programmer prog_u (.sck_o(sck), .mosi_o(mosi), .ext_reset_b_o(ext_b), .miso_i(miso));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [31:0] w, input logic [7:0] exp);
    prog_u.send(w, r);
    chk(r[7:0], exp);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    chk({7'h00, busy}, 8'h01);
    while (busy !== 1'b0 && n < 40000)
    begin
      @(posedge clk);
      #2;
      n++;
    end
    chk({7'h00, busy}, 8'h00);
  endtask

  task automatic t_start();
    chk({2'b00, lock}, 8'h3f);
    chk(f_lo, 8'hff);
    chk({6'h00, f_ext}, 8'h03);
    chk({7'h00, mode}, 8'h00);
    chk({7'h00, miso_oe}, 8'h00);
    prog_u.start();
    chk({7'h00, mode}, 8'h01);
    chk({7'h00, miso_oe}, 8'h01);
    prog_u.send(32'hac_a0_00_00, r);
    chk(f_lo, 8'hff);
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, en}, 8'h00);
  endtask

  task automatic t_enable();
    prog_u.send(32'hac_53_5a_a5, r);
    chk(r[15:8], 8'h53);
    chk({7'h00, en}, 8'h01);
  endtask

  task automatic t_erase();
    prog_u.send(32'hac_9f_12_34, r);
    wait_idle();
    rd(32'ha0_07_ff_00, 8'hff);
    rd(32'h28_7f_ff_00, 8'hff);
  endtask

  task automatic t_data();
    prog_u.send(32'hc0_f9_45_a5, r);
    prog_u.send(32'hc0_00_46_77, r);
    rd(32'ha0_01_45_00, 8'hff);
    wait_idle();
    rd(32'ha0_f9_45_00, 8'ha5);
    rd(32'ha0_01_44_00, 8'hff);
    rd(32'ha0_00_46_00, 8'hff);
  endtask

  task automatic t_page();
    prog_u.send(32'h40_ff_85_34, r);
    prog_u.send(32'h48_00_05_12, r);
    prog_u.send(32'h4c_01_00_00, r);
    rd(32'h20_01_05_00, 8'hff);
    wait_idle();
    rd(32'h20_01_05_00, 8'h34);
    rd(32'h28_81_05_00, 8'h12);
    rd(32'h20_00_05_00, 8'hff);
  endtask

  task automatic t_lock();
    prog_u.send(32'hac_e0_00_c5, r);
    wait_idle();
    chk({2'b00, lock}, 8'h05);
    rd(32'h58_00_00_00, 8'hc5);
  endtask

  task automatic t_fuse();
    logic [7:0]  sel [3] = '{8'ha0, 8'ha8, 8'ha4};
    logic [15:0] op [3] = '{16'h50_00, 16'h58_08, 16'h50_08};
    logic [7:0]  val [3] = '{8'h5a, 8'h3c, 8'hfe};
    for (int i = 0; i < 3; i++)
    begin
      prog_u.send({8'hac, sel[i], 8'h00, val[i]}, r);
      wait_idle();
      rd({op[i], 16'h0000}, val[i]);
    end
    chk(f_hi, 8'h3c);
    chk({6'h00, f_ext}, 8'h02);
  endtask

  task automatic t_exit();
    prog_u.stop();
    chk({7'h00, mode}, 8'h00);
    chk({7'h00, en}, 8'h00);
    prog_u.start();
    prog_u.send(32'hac_a8_00_00, r);
    chk(f_hi, 8'h3c);
    chk({7'h00, busy}, 8'h00);
    t_enable();
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // erase dominates the run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      test_done();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk);
    #2 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    t_start();
    t_enable();
    t_erase();
    t_data();
    t_page();
    t_lock();
    t_fuse();
    t_exit();
    test_done();
  end
endmodule

`default_nettype wire
